// File: src/ccio_pkg.sv
// Package of constants for the cascade contact I/O block
package ccio_pkg;
  localparam int CCIO_DATA_W = 16;
  localparam int CCIO_PID_SETS = 8;
  localparam int CCIO_PID_AW = 3;
  localparam logic [4:0] CCIO_PATTERN_OFFSET = 5'h10;
  localparam logic [4:0] CCIO_PATTERN_RST = 5'h01;
  localparam logic [2:0] CCIO_RET_PV = 3'h1;
  localparam logic [2:0] CCIO_RET_SP = 3'h2;
  localparam logic [2:0] CCIO_RET_OUT = 3'h3;
  localparam logic [2:0] CCIO_RET_LOOP_PWR = 3'h4;
  localparam logic [2:0] CCIO_RET_RST = 3'h1;
  localparam logic [7:0] CCIO_REG_CTRL = 8'h00;
  localparam logic [7:0] CCIO_REG_PRESET = 8'h04;
  localparam logic [7:0] CCIO_REG_STATUS = 8'h08;
  localparam logic [7:0] CCIO_REG_PATTERN = 8'h0C;
  localparam logic [7:0] CCIO_REG_PID_BASE = 8'h40;
  localparam logic [15:0] CCIO_PRESET_RST = 16'h0000;
  typedef enum logic [2:0] {
    CCIO_ST_IDLE = 3'b001,
    CCIO_ST_RUN = 3'b010,
    CCIO_ST_LOCAL = 3'b100
  } ccio_state_t;
endpackage

// File: src/ccio_pid_mem.sv
// Memory of PID tuning sets, registered read data
module ccio_pid_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int W = 48
) (
  // Clock
  input wire logic i_sys_clk,
  // Write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  // Read port
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);
  logic [W-1:0] mem [DEPTH];
  initial begin
    if (DEPTH > (1 << AW)) begin
      $error("depth exceeds address range");
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

// File: src/ccio_top.sv
// Contact input and output control of the cascade primary loop
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
module ccio_top
  import ccio_pkg::*;
#(
  parameter int DATA_W = CCIO_DATA_W,
  parameter int PID_SETS = CCIO_PID_SETS
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Contact inputs
  input wire logic i_pattern_select_bit0,
  input wire logic i_pattern_select_bit1,
  input wire logic i_pattern_select_bit2,
  input wire logic i_pattern_select_bit3,
  input wire logic i_run_request_contact,
  input wire logic i_stop_request_contact,
  input wire logic i_tracking_switch_contact,
  input wire logic i_pattern_offset_contact,
  // Analog values from the secondary loop and the computing core
  input wire logic [DATA_W-1:0] i_tracking_analog_in,
  input wire logic [DATA_W-1:0] i_pid_result,
  input wire logic [DATA_W-1:0] i_process_value,
  input wire logic [DATA_W-1:0] i_program_setpoint,
  // Events from the computing core
  input wire logic i_process_event_a,
  input wire logic i_process_event_b,
  input wire logic i_instrument_alarm,
  input wire logic i_time_event_a,
  input wire logic i_time_event_b,
  input wire logic i_time_event_c,
  input wire logic i_fail,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // Analog results and mode signals
  output logic [DATA_W-1:0] o_manipulated_output,
  output logic [DATA_W-1:0] o_retransmit_output,
  output logic o_loop_power_enable,
  output logic o_compute_enable,
  output logic o_compute_preload,
  output logic [DATA_W-1:0] o_preload_value,
  output logic [4:0] o_pattern_number,
  output logic o_program_running,
  output logic o_local_mode,
  // Contact outputs
  output logic o_process_event_a_out,
  output logic o_process_event_b_out,
  output logic o_instrument_alarm_out,
  output logic o_time_event_a_out,
  output logic o_time_event_b_out,
  output logic o_time_event_c_out,
  output logic o_health_ok_out
);
  localparam int PID_W = 3 * DATA_W;
  localparam int NDI = 8;
  default clocking ccio_cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  // Three fields must cover the 32-bit register word
  if (DATA_W < 11 || DATA_W > 16 || PID_SETS != 8) begin : g_param_chk
    $error("DATA_W must be 11 to 16 and PID_SETS 8");
  end

  // Two-stage synchroniser per contact; only stage two is read
  logic [NDI-1:0] di_raw;
  logic [NDI-1:0] sync1_r;
  logic [NDI-1:0] sync2_r;
  logic [NDI-1:0] prev_r;
  logic [NDI-1:0] rise;
  assign di_raw = {i_pattern_offset_contact, i_tracking_switch_contact,
                   i_stop_request_contact, i_run_request_contact,
                   i_pattern_select_bit3, i_pattern_select_bit2,
                   i_pattern_select_bit1, i_pattern_select_bit0};

  genvar g;
  generate
    for (g = 0; g < NDI; g++) begin : g_sync
      always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
          prev_r[g] <= 1'b0;
        end else begin
          sync1_r[g] <= di_raw[g];
          sync2_r[g] <= sync1_r[g];
          prev_r[g] <= sync2_r[g];
        end
      end
      assign rise[g] = sync2_r[g] & ~prev_r[g];
    end
  endgenerate

  logic run_rise;
  logic stop_rise;
  logic trk_rise;
  logic trk_on;
  assign run_rise = rise[4];
  assign stop_rise = rise[5];
  assign trk_rise = rise[6];
  assign trk_on = sync2_r[6];

  // Register state
  logic [2:0] ret_sel_r;
  logic [2:0] ret_sel_nxt;
  logic [DATA_W-1:0] preset_r;
  logic [DATA_W-1:0] preset_nxt;
  logic [CCIO_PID_AW-1:0] pid_sel_r;
  logic [CCIO_PID_AW-1:0] pid_sel_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic pid_rd_r;
  logic pid_rd_nxt;
  logic pid_we;
  logic [CCIO_PID_AW-1:0] pid_addr;
  logic [PID_W-1:0] pid_rdata;
  logic [PID_W-1:0] pid_wdata;

  // Mode state
  ccio_state_t state_r;
  ccio_state_t state_nxt;
  logic [4:0] pattern_r;
  logic [4:0] pattern_nxt;
  logic [DATA_W-1:0] trk_latch_r;
  logic [DATA_W-1:0] trk_latch_nxt;
  logic trk_was_r;
  logic preload_nxt;
  logic [DATA_W-1:0] mv_nxt;
  logic [DATA_W-1:0] ret_nxt;

  // PID sets addressed at base plus four per set, three fields packed
  assign pid_addr = i_reg_addr[CCIO_PID_AW+1:2];
  assign pid_we = i_reg_wr && (i_reg_addr[7:6] == CCIO_REG_PID_BASE[7:6]);
  assign pid_wdata = {PID_W{1'b0}} | PID_W'(i_reg_wdata);

  ccio_pid_mem #(
    .DEPTH(PID_SETS),
    .AW(CCIO_PID_AW),
    .W(PID_W)
  ) u_pid_mem (
    .i_sys_clk(i_sys_clk),
    .i_we(pid_we),
    .i_waddr(pid_addr),
    .i_wdata(pid_wdata),
    .i_raddr(pid_rd_nxt ? pid_addr : pid_sel_r),
    .o_rdata(pid_rdata)
  );

  always_comb begin
    ret_sel_nxt = ret_sel_r;
    preset_nxt = preset_r;
    pid_sel_nxt = pid_sel_r;
    rdata_nxt = 32'h0;
    pid_rd_nxt = 1'b0;
    if (i_reg_wr) begin
      if (i_reg_addr == CCIO_REG_CTRL) begin
        ret_sel_nxt = i_reg_wdata[2:0];
        pid_sel_nxt = i_reg_wdata[6:4];
      end else if (i_reg_addr == CCIO_REG_PRESET) begin
        preset_nxt = i_reg_wdata[DATA_W-1:0];
      end
    end
    if (i_reg_rd) begin
      if (i_reg_addr[7:6] == CCIO_REG_PID_BASE[7:6]) begin
        pid_rd_nxt = 1'b1;
      end else begin
        unique case (i_reg_addr)
          CCIO_REG_CTRL: rdata_nxt = {25'h0, pid_sel_r, 1'b0, ret_sel_r};
          CCIO_REG_PRESET: rdata_nxt = 32'(preset_r);
          CCIO_REG_STATUS: rdata_nxt = {28'h0, trk_on, state_r};
          CCIO_REG_PATTERN: rdata_nxt = {27'h0, pattern_r};
          default: rdata_nxt = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ret_sel_r <= CCIO_RET_RST;
      preset_r <= DATA_W'(CCIO_PRESET_RST);
      pid_sel_r <= '0;
      rdata_r <= 32'h0;
      pid_rd_r <= 1'b0;
    end else begin
      ret_sel_r <= ret_sel_nxt;
      preset_r <= preset_nxt;
      pid_sel_r <= pid_sel_nxt;
      rdata_r <= rdata_nxt;
      pid_rd_r <= pid_rd_nxt;
    end
  end
  assign o_reg_rdata = pid_rd_r ? pid_rdata[31:0] : rdata_r;

  // Mode sequencing; stop outranks run, tracking edge outranks both
  always_comb begin
    state_nxt = state_r;
    pattern_nxt = pattern_r;
    trk_latch_nxt = trk_on ? i_tracking_analog_in : trk_latch_r;
    preload_nxt = trk_was_r && !trk_on;
    unique case (state_r)
      CCIO_ST_IDLE: begin
        pattern_nxt = {1'b0, sync2_r[3:0]}
          + (sync2_r[7] ? CCIO_PATTERN_OFFSET : 5'h00);
        if (trk_rise) begin
          state_nxt = CCIO_ST_LOCAL;
        end else if (run_rise && !stop_rise) begin
          state_nxt = CCIO_ST_RUN;
        end
      end
      CCIO_ST_RUN, CCIO_ST_LOCAL: begin
        if (trk_rise) begin
          state_nxt = CCIO_ST_LOCAL;
        end else if (stop_rise) begin
          state_nxt = CCIO_ST_IDLE;
        end else if (run_rise) begin
          state_nxt = CCIO_ST_RUN;
        end
      end
      default: state_nxt = CCIO_ST_IDLE;
    endcase
    // Tracking overrides all; preset only when halted without it
    if (trk_on) begin
      mv_nxt = i_tracking_analog_in;
    end else if (state_r == CCIO_ST_IDLE) begin
      mv_nxt = preset_r;
    end else begin
      mv_nxt = i_pid_result;
    end
    unique case (ret_sel_r)
      CCIO_RET_PV: ret_nxt = i_process_value;
      CCIO_RET_SP: ret_nxt = i_program_setpoint;
      CCIO_RET_OUT: ret_nxt = o_manipulated_output;
      default: ret_nxt = '0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_r <= CCIO_ST_IDLE;
      pattern_r <= CCIO_PATTERN_RST;
      trk_latch_r <= '0;
      trk_was_r <= 1'b0;
      o_manipulated_output <= '0;
      o_retransmit_output <= '0;
      o_loop_power_enable <= 1'b0;
      o_compute_enable <= 1'b0;
      o_compute_preload <= 1'b0;
      o_preload_value <= '0;
      o_process_event_a_out <= 1'b0;
      o_process_event_b_out <= 1'b0;
      o_instrument_alarm_out <= 1'b0;
      o_time_event_a_out <= 1'b0;
      o_time_event_b_out <= 1'b0;
      o_time_event_c_out <= 1'b0;
      o_health_ok_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pattern_r <= pattern_nxt;
      trk_latch_r <= trk_latch_nxt;
      trk_was_r <= trk_on;
      o_manipulated_output <= mv_nxt;
      o_retransmit_output <= ret_nxt;
      o_loop_power_enable <= (ret_sel_r == CCIO_RET_LOOP_PWR);
      o_compute_enable <= !trk_on && (state_r != CCIO_ST_IDLE);
      o_compute_preload <= preload_nxt;
      o_preload_value <= trk_latch_r;
      o_process_event_a_out <= i_process_event_a;
      o_process_event_b_out <= i_process_event_b;
      o_instrument_alarm_out <= i_instrument_alarm;
      o_time_event_a_out <= i_time_event_a;
      o_time_event_b_out <= i_time_event_b;
      o_time_event_c_out <= i_time_event_c;
      o_health_ok_out <= !i_fail;
    end
  end
  assign o_pattern_number = pattern_r;
  assign o_program_running = state_r[1];
  assign o_local_mode = state_r[2];

  // Assertions
  chk_track_passes: assert property (trk_on |=>
    o_manipulated_output == $past(i_tracking_analog_in))
    else $error("tracking value not passed");
  chk_pid_passes: assert property (!trk_on && state_r != CCIO_ST_IDLE
    |=> o_manipulated_output == $past(i_pid_result))
    else $error("pid result not passed");
  chk_preset_out: assert property (!trk_on && state_r == CCIO_ST_IDLE
    |=> o_manipulated_output == $past(preset_r))
    else $error("preset not output when halted");
  chk_pattern_hold: assert property (state_r == CCIO_ST_RUN
    |=> $stable(pattern_r))
    else $error("pattern changed while running");
  chk_pattern_offset: assert property (state_r == CCIO_ST_IDLE
    && sync2_r[7] |=> pattern_r[4])
    else $error("offset not applied");
  chk_run_start: assert property (state_r == CCIO_ST_IDLE && run_rise
    && !stop_rise && !trk_rise |=> state_r == CCIO_ST_RUN)
    else $error("run edge did not start");
  chk_stop_halt: assert property (state_r == CCIO_ST_RUN && stop_rise
    && !trk_rise |=> state_r == CCIO_ST_IDLE)
    else $error("stop edge did not halt");
  chk_local_entry: assert property (trk_rise
    |=> state_r == CCIO_ST_LOCAL)
    else $error("local mode not entered");
  chk_resume_preload: assert property ($fell(trk_on) |=>
    o_compute_preload && o_preload_value == $past(i_tracking_analog_in, 2))
    else $error("preload value wrong");
  chk_health_out: assert property (i_fail |=> !o_health_ok_out)
    else $error("health on during fail");
  chk_loop_power: assert property (ret_sel_r == CCIO_RET_LOOP_PWR
    |=> o_loop_power_enable && o_retransmit_output == '0)
    else $error("loop power mode wrong");
  chk_edge_once: assert property (run_rise |=> !run_rise)
    else $error("edge seen twice");
endmodule

// File: verification/ccio_secondary_model.sv
// Behavioural secondary-loop controller facing the primary loop
module ccio_secondary_model (
  // Clock and commands from the bench
  input wire logic i_sys_clk,
  input wire logic i_leave_cascade,
  input wire logic [15:0] i_output_level,
  // Toward the primary loop
  output logic o_tracking_contact,
  output logic [15:0] o_tracking_analog
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_tracking_contact = 1'b0;
    o_tracking_analog = 16'h0000;
  end
  // Contact high while out of cascade; value always driven
  always @(posedge i_sys_clk) begin
    o_tracking_contact <= i_leave_cascade;
    o_tracking_analog <= i_output_level;
  end
endmodule

// File: verification/ccio_top_tb.sv
// Self-checking bench for the cascade contact I/O block
module ccio_top_tb import ccio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int sel; logic [31:0] exp;} ccio_note_t;
  logic clk, rst, run, stop, ofs, leave, wr, rd, trk;
  logic [3:0] pat;
  logic [6:0] ev, evo;
  logic [15:0] lvl, pid, pv, sp, pre, mo, ro, prel, trka;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, exp;
  logic [31:0] w [8];
  logic lpe, ce, runo, loc, cpl;
  logic [4:0] pn;
  ccio_note_t notes[$];
  ccio_note_t n;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int i;
  int unsigned seed;

  ccio_secondary_model u_sec (.i_sys_clk(clk), .i_leave_cascade(leave),
    .i_output_level(lvl), .o_tracking_contact(trk),
    .o_tracking_analog(trka));

  ccio_top u_dut (.i_sys_clk(clk), .i_reset(rst),
    .i_pattern_select_bit0(pat[0]), .i_pattern_select_bit1(pat[1]),
    .i_pattern_select_bit2(pat[2]), .i_pattern_select_bit3(pat[3]),
    .i_run_request_contact(run), .i_stop_request_contact(stop),
    .i_tracking_switch_contact(trk), .i_pattern_offset_contact(ofs),
    .i_tracking_analog_in(trka), .i_pid_result(pid),
    .i_process_value(pv), .i_program_setpoint(sp),
    .i_process_event_a(ev[0]), .i_process_event_b(ev[1]),
    .i_instrument_alarm(ev[2]), .i_time_event_a(ev[3]),
    .i_time_event_b(ev[4]), .i_time_event_c(ev[5]), .i_fail(ev[6]),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .o_manipulated_output(mo),
    .o_retransmit_output(ro), .o_loop_power_enable(lpe),
    .o_compute_enable(ce), .o_compute_preload(cpl),
    .o_preload_value(prel), .o_pattern_number(pn),
    .o_program_running(runo), .o_local_mode(loc),
    .o_process_event_a_out(evo[0]), .o_process_event_b_out(evo[1]),
    .o_instrument_alarm_out(evo[2]), .o_time_event_a_out(evo[3]),
    .o_time_event_b_out(evo[4]), .o_time_event_c_out(evo[5]),
    .o_health_ok_out(evo[6]));

  function automatic logic [31:0] observe(int sel);
    case (sel)
      0: return rdata;
      1: return {16'h0000, mo};
      2: return {15'h0000, lpe, ro};
      3: return {27'h0, pn};
      4: return {29'h0, runo, loc, ce};
      5: return {25'h0, evo};
      6: return {31'h0, cpl};
      default: return {16'h0000, prel};
    endcase
  endfunction

  task automatic check(logic [31:0] seen, logic [31:0] e);
    checked++;
    if (seen !== e) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, e);
    end
  endtask

  task automatic note(int sel, logic [31:0] e);
    notes.push_back('{sel, e});
  endtask

  task automatic tick(int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic reg_wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    note(0, e);
  endtask

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Notes are compared mid-cycle, away from the driving edge
  always @(negedge clk) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      check(observe(n.sel), n.exp);
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    {pat, run, stop, ofs, leave, wr, rd} = '0;
    {lvl, pid, pv, sp, pre, ev, addr, wdata} = '0;
    rst = 1'b1;
    seed = $urandom(32'h302DD4C3);
    pv = 16'($urandom);
    sp = 16'($urandom);
    pid = 16'($urandom);
    pre = 16'($urandom);
    tick(8);
    rst <= 1'b0;
    reg_rd(CCIO_REG_CTRL, 32'h1);
    reg_rd(CCIO_REG_STATUS, 32'h1);
    for (i = 0; i < 8; i++) begin
      ev <= 7'($urandom);
      tick(2);
      note(5, {25'h0, ~ev[6], ev[5:0]});
    end
    $display("test contact outputs done");
    for (i = 0; i < 32; i++) begin
      pat <= i[3:0];
      ofs <= i[4];
      tick(4);
      note(3, 32'(i));
    end
    reg_rd(CCIO_REG_PATTERN, 32'h1F);
    $display("test patterns done");
    reg_wr(CCIO_REG_PRESET, {16'h0000, pre});
    reg_rd(CCIO_REG_PRESET, {16'h0000, pre});
    tick(2);
    note(1, {16'h0000, pre});
    pat <= 4'h5;
    ofs <= 1'b0;
    tick(4);
    run <= 1'b1;
    tick(6);
    note(4, 32'h5);
    note(1, {16'h0000, pid});
    pat <= 4'hA;
    pid <= 16'($urandom);
    tick(6);
    note(3, 32'h5);
    note(1, {16'h0000, pid});
    $display("test run done");
    leave <= 1'b1;
    lvl <= 16'($urandom);
    tick(6);
    note(4, 32'h2);
    note(1, {16'h0000, lvl});
    lvl <= 16'($urandom);
    tick(3);
    note(1, {16'h0000, lvl});
    leave <= 1'b0;
    tick(4);
    note(6, 32'h1);
    tick(2);
    note(6, 32'h0);
    note(7, {16'h0000, lvl});
    note(4, 32'h3);
    note(1, {16'h0000, pid});
    lvl <= ~lvl;
    run <= 1'b0;
    tick(2);
    run <= 1'b1;
    tick(6);
    note(4, 32'h5);
    stop <= 1'b1;
    tick(6);
    note(4, 32'h0);
    note(1, {16'h0000, pre});
    tick(10);
    reg_rd(CCIO_REG_STATUS, 32'h1);
    $display("test tracking and stop done");
    for (i = 0; i < 8; i++) begin
      reg_wr(CCIO_REG_CTRL, 32'(i));
      tick(2);
      exp = (i == 1) ? pv : (i == 2) ? sp : (i == 3) ? pre : 16'h0000;
      note(2, {15'h0000, i == 4, exp[15:0]});
    end
    $display("test retransmit done");
    for (i = 0; i < 8; i++) begin
      w[i] = $urandom;
      reg_wr(CCIO_REG_PID_BASE + 8'(4 * i), w[i]);
    end
    for (i = 0; i < 8; i++)
      reg_rd(CCIO_REG_PID_BASE + 8'(4 * i), w[i]);
    reg_wr(8'h20, $urandom);
    reg_rd(8'h20, 32'h0);
    $display("test tuning sets done");
    tick(4);
    report_and_stop();
  end
endmodule
